//--- design/kms_key_scan.sv
// key matrix scanner with open-drain read request and serial link front end
module kms_key_scan #(
    parameter int OSC_DIV = kms_pkg::OSC_DIV_DEF
) (
    // system clock domain
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    // serial link
    input wire logic sclLink,
    input wire logic ceLink,
    input wire logic siLink,
    output logic soOut,
    output logic soOe,
    // key matrix
    output logic [5:0] scanDrive,
    input wire logic [4:0] retSense,
    // status
    output logic displayOn,
    output logic keyPending,
    output kms_pkg::kms_cfg_t cfgOut
);
    import kms_pkg::*;

    if (OSC_DIV < 1 || OSC_DIV > 255) begin : g_chk
        $error("OSC_DIV must be 1 to 255");
    end

    localparam logic [7:0] DIV_LAST = 8'(OSC_DIV - 1);

    kms_sys_t s;
    kms_sys_t next_s;
    kms_link_t l;
    kms_link_t next_l;

    logic saveMode;
    logic scanning;
    logic tick;
    logic oscRun;
    logic keyIdle;
    logic multiKey;
    logic ceRise;
    logic ceFall;
    logic [5:0] lineMask;
    logic [5:0] lineHot;
    logic [5:0] driveNow;
    logic [4:0] retMasked;
    logic [7:0] minBits;
    logic [4:0] rdPos;
    logic soBit;

    // derived conditions
    always_comb begin
        saveMode = s.cfg.saveLo | s.cfg.saveHi;
        scanning = (s.st == ST_SCAN1) || (s.st == ST_SCAN2);
        case (s.cfg.lineSel)
            2'h0: lineMask = DRIVE_ALL;
            2'h1: lineMask = 6'h3E;
            default: lineMask = 6'h3C;
        endcase
        if (s.cfg.saveLo && !s.cfg.saveHi) begin
            lineMask = lineMask & SAVE1_LINES;
        end else if (s.cfg.saveHi && !s.cfg.saveLo) begin
            lineMask = lineMask & SAVE2_LINES;
        end
        lineHot = 6'h01 << s.line;
        keyIdle = |s.retS2;
        multiKey = $countones(s.keyMap) > 1;
        oscRun = !s.por && (!saveMode || s.st != ST_IDLE || keyIdle);
        tick = oscRun && (s.divCnt == DIV_LAST);
        retMasked = s.retS2 & {NUM_RET{lineMask[s.line]}};
        ceRise = s.ceS2 && !s.ceLast;
        ceFall = !s.ceS2 && s.ceLast;
        minBits = s.cfg.dutyQuarter ? MIN_BITS_QUARTER : MIN_BITS_THIRD;
        if (s.por) begin
            driveNow = DRIVE_RESET;
        end else if (scanning) begin
            driveNow = lineHot & lineMask;
        end else if (s.st == ST_HOLD && multiKey) begin
            driveNow = DRIVE_ALL;
        end else if (saveMode) begin
            driveNow = lineMask;
        end else begin
            driveNow = DRIVE_ALL;
        end
    end

    // system domain next state
    always_comb begin
        logic [1:0] frameId;
        logic [3:0] newSeen;
        logic [3:0] full;
        frameId = l.shReg[FRAME_ID_LSB +: 2];
        newSeen = s.seen;
        full = FRAMES_THIRD;
        next_s = s;
        next_s.ceS1 = ceLink;
        next_s.ceS2 = s.ceS1;
        next_s.ceLast = s.ceS2;
        next_s.sclS1 = sclLink;
        next_s.sclS2 = s.sclS1;
        next_s.retS1 = retSense;
        next_s.retS2 = s.retS1;
        next_s.drive = driveNow;
        next_s.word = s.por ? '1 : {saveMode, s.keyMap};
        next_s.divCnt = (oscRun && !tick) ? s.divCnt + 8'h01 : 8'h00;
        if (s.st == ST_IDLE || s.st == ST_OFF) begin
            next_s.confT = 11'h000;
        end else if (tick && s.confT != 11'h7FF) begin
            next_s.confT = s.confT + 11'h001;
        end
        case (s.st)
            ST_OFF: begin
                next_s.keyMap = '0;
            end
            ST_IDLE: begin
                if (tick && keyIdle) begin
                    next_s.st = ST_SCAN1;
                    next_s.slot = 6'h00;
                    next_s.line = 3'h0;
                    next_s.capA = '0;
                end
            end
            ST_SCAN1, ST_SCAN2: begin
                if (tick) begin
                    if (s.slot == 6'(SLOT_T - 1)) begin
                        next_s.slot = 6'h00;
                        if (s.st == ST_SCAN1) begin
                            next_s.capA[s.line * NUM_RET +: NUM_RET] = retMasked;
                        end else begin
                            next_s.capB[s.line * NUM_RET +: NUM_RET] = retMasked;
                        end
                        if (s.line == 3'(NUM_LINES - 1)) begin
                            next_s.line = 3'h0;
                            next_s.capB = (s.st == ST_SCAN1) ? '0 : next_s.capB;
                            next_s.st = (s.st == ST_SCAN1) ? ST_SCAN2 : ST_CHECK;
                        end else begin
                            next_s.line = s.line + 3'h1;
                        end
                    end else begin
                        next_s.slot = s.slot + 6'h01;
                    end
                end
            end
            ST_CHECK: begin
                if (tick) begin
                    if (s.capA == s.capB && |s.capA) begin
                        next_s.keyMap = s.capA;
                        next_s.pend = 1'b1;
                        next_s.st = ST_HOLD;
                    end else if (keyIdle) begin
                        next_s.st = ST_GAP;
                        next_s.gapCnt = 11'h000;
                    end else begin
                        next_s.st = ST_IDLE;
                    end
                end
            end
            ST_GAP: begin
                if (tick) begin
                    if (s.gapCnt == 11'(GAP_T - 1)) begin
                        next_s.st = ST_SCAN1;
                        next_s.slot = 6'h00;
                        next_s.line = 3'h0;
                        next_s.capA = '0;
                    end else begin
                        next_s.gapCnt = s.gapCnt + 11'h001;
                    end
                end
            end
            ST_HOLD: begin
                next_s.st = ST_HOLD;
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase
        if (ceRise) begin
            next_s.readMode = !s.sclS2;
            next_s.frameTgl = !s.frameTgl;
        end
        if (ceFall) begin
            if (s.readMode) begin
                if (s.pend && !s.por) begin
                    next_s.pend = 1'b0;
                    next_s.st = ST_IDLE;
                end
            end else if (l.bitCnt >= minBits && (s.cfg.dutyQuarter || frameId != 2'h3)) begin
                if (frameId == 2'h0) begin
                    next_s.cfg.saveLo = l.shReg[SAVE_LO_BIT];
                    next_s.cfg.saveHi = l.shReg[SAVE_HI_BIT];
                    next_s.cfg.lineSel = l.shReg[LINE_SEL_LSB +: 2];
                    if (s.seen == 4'h0) begin
                        next_s.cfg.dutyQuarter = l.shReg[DUTY_BIT];
                    end
                end
                newSeen = s.seen | (4'h1 << frameId);
                next_s.seen = newSeen;
                full = next_s.cfg.dutyQuarter ? FRAMES_QUARTER : FRAMES_THIRD;
                if (s.por && (newSeen & full) == full) begin
                    next_s.por = 1'b0;
                    next_s.displayOn = 1'b1;
                    next_s.st = ST_IDLE;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= SYS_RST;
        end else if (clkEn) begin
            s <= next_s;
        end
    end

    // link domain: serial shift in and read bit index
    always_comb begin
        logic newFrame;
        newFrame = l.seenTgl != s.frameTgl;
        next_l = l;
        next_l.rstS1 = rst;
        next_l.rstS2 = l.rstS1;
        if (l.rstS2) begin
            next_l = LINK_RST;
            next_l.rstS1 = rst;
            next_l.rstS2 = l.rstS1;
        end else if (ceLink) begin
            next_l.seenTgl = s.frameTgl;
            next_l.shReg = {l.shReg[SHIFT_W-2:0], siLink};
            if (newFrame) begin
                next_l.bitCnt = 8'h01;
                next_l.rdIdx = 5'h01;
            end else begin
                next_l.bitCnt = (l.bitCnt == 8'hFF) ? 8'hFF : l.bitCnt + 8'h01;
                next_l.rdIdx = (l.rdIdx == RD_DONE) ? RD_DONE : l.rdIdx + 5'h01;
            end
        end
    end

    always_ff @(posedge sclLink) begin
        l <= next_l;
    end

    // open-drain output: read data while reading, else the request
    always_comb begin
        rdPos = (l.seenTgl == s.frameTgl) ? l.rdIdx : 5'h00;
        soBit = (rdPos == RD_DONE) ? 1'b1 : s.word[rdPos];
        if (s.readMode && s.ceS2) begin
            soOe = !soBit;
        end else begin
            soOe = s.pend && !s.ceS2 && !s.por;
        end
    end

    assign soOut = 1'b0;
    assign scanDrive = s.drive;
    assign displayOn = s.displayOn;
    assign keyPending = s.pend;
    assign cfgOut = s.cfg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_req_low: assert property (s.pend && !s.ceS2 && !s.por |-> soOe)
        else $error("request not pulled low");
    a_ce_float: assert property (s.ceS2 && !s.readMode |-> !soOe)
        else $error("request driven during write");
    a_read_release: assert property (clkEn && ceFall && s.readMode && s.pend |=> !s.pend
        && s.st == ST_IDLE)
        else $error("read did not release request");
    a_save_kept: assert property (clkEn && ceFall && s.readMode |=> $stable(s.cfg))
        else $error("read changed configuration");
    a_cfg_at_fall: assert property (!ceFall |=> $stable(s.cfg))
        else $error("configuration changed outside chip-select fall");
    a_hold_kept: assert property (s.pend && !(ceFall && s.readMode) |=> s.pend
        && $stable(s.keyMap) && s.st == ST_HOLD)
        else $error("held map lost");
    a_confirm_eq: assert property ($rose(s.pend) |-> s.keyMap == s.capB)
        else $error("map fixed without agreement");
    a_confirm_time: assert property ($rose(s.pend) |-> s.confT == 11'(CONFIRM_T)
        || s.confT >= 11'(RESCAN_T))
        else $error("request time wrong");
    a_reset_lines: assert property (s.por |=> scanDrive == DRIVE_RESET)
        else $error("reset scan levels wrong");
    a_reset_map: assert property (s.por |-> s.keyMap == '0 && !s.pend && !tick)
        else $error("reset state wrong");
    a_reset_read: assert property (s.por && s.ceS2 && s.readMode |-> !soOe)
        else $error("read in reset not all ones");
    a_idle_high: assert property (s.st == ST_IDLE && !saveMode |=> scanDrive == DRIVE_ALL
        || !clkEn)
        else $error("idle lines not high");
    a_scan_hot: assert property (scanning |=> $onehot0(scanDrive) || !clkEn)
        else $error("scan pattern not one-hot");

    c_first_pair: cover property ($rose(s.pend) && s.confT == 11'(CONFIRM_T));
    c_second_pair: cover property ($rose(s.pend) && s.confT == 11'(RESCAN_T));
    c_read_done: cover property (ceFall && s.readMode && s.pend);
    c_por_release: cover property ($fell(s.por));
endmodule : kms_key_scan

//--- design/kms_pkg.sv
// shared constants, types and state records of the key matrix scanner
package kms_pkg;
    localparam int NUM_LINES = 6;
    localparam int NUM_RET = 5;
    localparam int KEY_BITS = 30;
    localparam int SHIFT_W = 64;
    // scan timing in oscillator periods
    localparam int SCAN_T = 288;
    localparam int SLOT_T = SCAN_T / NUM_LINES;
    localparam int CONFIRM_T = 577;
    localparam int RESCAN_T = 1200;
    localparam int GAP_T = RESCAN_T - 2 * CONFIRM_T;
    localparam int OSC_DIV_DEF = 4;
    // minimum frame lengths per duty
    localparam logic [7:0] MIN_BITS_THIRD = 8'h38;
    localparam logic [7:0] MIN_BITS_QUARTER = 8'h3A;
    // instruction field positions, counted from the last bit shifted in, and frame id sets per duty
    localparam int FRAME_ID_LSB = 0;
    localparam int DUTY_BIT = 2;
    localparam int SAVE_LO_BIT = 3;
    localparam int SAVE_HI_BIT = 4;
    localparam int LINE_SEL_LSB = 5;
    localparam logic [3:0] FRAMES_THIRD = 4'h7;
    localparam logic [3:0] FRAMES_QUARTER = 4'hF;
    // scan line patterns and the read end index
    localparam logic [5:0] DRIVE_ALL = 6'h3F;
    localparam logic [5:0] DRIVE_RESET = 6'h20;
    localparam logic [5:0] SAVE1_LINES = 6'h20;
    localparam logic [5:0] SAVE2_LINES = 6'h30;
    localparam logic [4:0] RD_DONE = 5'h1F;

    typedef enum logic [2:0] {
        ST_OFF, ST_IDLE, ST_SCAN1, ST_SCAN2, ST_CHECK, ST_GAP, ST_HOLD
    } kms_state_t;

    typedef struct packed {
        logic saveLo;
        logic saveHi;
        logic [1:0] lineSel;
        logic dutyQuarter;
    } kms_cfg_t;

    localparam kms_cfg_t CFG_RST = '0;

    typedef struct packed {
        kms_state_t st;
        logic por;
        logic displayOn;
        kms_cfg_t cfg;
        logic [3:0] seen;
        logic [KEY_BITS-1:0] keyMap;
        logic [KEY_BITS-1:0] capA;
        logic [KEY_BITS-1:0] capB;
        logic [KEY_BITS:0] word;
        logic pend;
        logic [7:0] divCnt;
        logic [5:0] slot;
        logic [2:0] line;
        logic [10:0] gapCnt;
        logic [10:0] confT;
        logic [5:0] drive;
        logic ceS1;
        logic ceS2;
        logic ceLast;
        logic sclS1;
        logic sclS2;
        logic readMode;
        logic frameTgl;
        logic [4:0] retS1;
        logic [4:0] retS2;
    } kms_sys_t;

    localparam kms_sys_t SYS_RST = '{
        st: ST_OFF, por: 1'b1, drive: DRIVE_RESET, word: '1, cfg: CFG_RST, default: '0
    };

    typedef struct packed {
        logic rstS1;
        logic rstS2;
        logic seenTgl;
        logic [SHIFT_W-1:0] shReg;
        logic [7:0] bitCnt;
        logic [4:0] rdIdx;
    } kms_link_t;

    localparam kms_link_t LINK_RST = '{rstS1: 1'b1, rstS2: 1'b1, default: '0};
endpackage : kms_pkg

//--- tb/kms_host_model.sv
// host side model: serial frame writes and key data reads
module kms_host_model (
    // serial link
    output logic sclLink,
    output logic ceLink,
    output logic siLink,
    // open-drain request and data
    input wire logic soOe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclLink = 1'b1;
        ceLink = 1'b0;
        siLink = 1'b0;
    end
    // link reset edges while reset is held
    task automatic pulse(input int k);
        repeat (k) begin
            #12 sclLink = 1'b0;
            #12 sclLink = 1'b1;
        end
    endtask : pulse
    task automatic write_frame(input logic [55:0] bits);
        sclLink = 1'b1;
        #10 ceLink = 1'b1;
        #200;
        for (int i = 55; i >= 0; i--) begin
            sclLink = 1'b0;
            siLink = bits[i];
            #16 sclLink = 1'b1;
            #16;
        end
        #200 ceLink = 1'b0;
        siLink = ~siLink;
    endtask : write_frame
    task automatic read_keys(output logic [30:0] bits);
        sclLink = 1'b0;
        #20 ceLink = 1'b1;
        #200;
        for (int k = 0; k < 31; k++) begin
            bits[k] = ~soOe;
            sclLink = 1'b1;
            #16 sclLink = 1'b0;
            #16;
        end
        #200 ceLink = 1'b0;
        #50 sclLink = 1'b1;
    endtask : read_keys
endmodule : kms_host_model

//--- tb/tb_kms_key_scan.sv
// testbench of the key matrix scanner with host model and key matrix
module tb_kms_key_scan;
    timeunit 1ns;
    timeprecision 1ps;
    import kms_pkg::*;
    logic clk_sys, rst, sclLink, ceLink, siLink, soOut, soOe;
    logic displayOn, keyPending, clkEn;
    logic [5:0] scanDrive;
    logic [4:0] retSense;
    kms_cfg_t cfgOut, c;
    logic [29:0] pressed;
    logic [31:0] seed;
    logic [30:0] rd;
    int failures, checked, n, k;
    kms_key_scan #(.OSC_DIV(1)) u_kms_key_scan (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn),
        .sclLink(sclLink), .ceLink(ceLink), .siLink(siLink), .soOut(soOut), .soOe(soOe),
        .scanDrive(scanDrive), .retSense(retSense), .displayOn(displayOn),
        .keyPending(keyPending), .cfgOut(cfgOut));
    kms_host_model u_kms_host_model (.sclLink(sclLink), .ceLink(ceLink), .siLink(siLink),
        .soOe(soOe));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    function automatic logic [4:0] ret_of(logic [5:0] d, logic [29:0] p);
        logic [4:0] r;
        r = '0;
        for (int l = 0; l < 6; l++) if (d[l]) r |= p[l*5 +: 5];
        return r;
    endfunction : ret_of
    always @(posedge clk_sys) retSense <= #2 ret_of(scanDrive, pressed);
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic [55:0] frame(logic [1:0] id, kms_cfg_t f, logic [31:0] r);
        logic [55:0] v;
        v = {r, r[23:0]};
        v[1:0] = id;
        if (id == 2'h0) v[6:2] = {f.lineSel, f.saveHi, f.saveLo, f.dutyQuarter};
        return v;
    endfunction : frame
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic chk_win(input int got, input int lo, input int hi, input string what);
        checked++;
        if (got < lo || got > hi) begin
            failures++;
            $display("BAD %0t %s took %0d", $time, what, got);
        end
    endtask : chk_win
    task automatic give_verdict();
        if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic wait_cyc(input int m);
        repeat (m) @(posedge clk_sys);
        #2;
    endtask : wait_cyc
    task automatic send(input logic [1:0] id);
        seed = xs(seed);
        u_kms_host_model.write_frame(frame(id, c, seed));
        wait_cyc(5);
    endtask : send
    task automatic wait_pend(output int cyc);
        cyc = 0;
        while (keyPending !== 1'b1) begin
            wait_cyc(1);
            cyc++;
            if (cyc > 3000) begin
                failures++;
                give_verdict();
            end
        end
    endtask : wait_pend
    task automatic read_chk(input logic [30:0] exp);
        pressed = '0;
        wait_cyc(2);
        u_kms_host_model.read_keys(rd);
        chk(32'(rd), 32'(exp), "key data");
        chk(32'($countones(rd[29:0]) > 3), 32'h0, "phantom map");
        wait_cyc(5);
        chk(32'(keyPending), 32'h0, "pend after read");
        chk(32'(soOe), 32'h0, "request released");
    endtask : read_chk
    initial begin
        rst = 1'b1;
        pressed = '0;
        clkEn = 1'b1;
        seed = 32'h49789E56;
        failures = 0;
        checked = 0;
        c = '0;
        fork
            u_kms_host_model.pulse(3);
            repeat (2) @(posedge clk_sys);
        join
        #2 rst = 1'b0;
        wait_cyc(1);
        chk(32'(scanDrive), 32'(DRIVE_RESET), "reset lines");
        chk(32'(soOe), 32'h0, "reset request");
        chk(32'(soOut), 32'h0, "open drain level");
        chk(32'(displayOn), 32'h0, "reset display");
        chk(32'(cfgOut), 32'h0, "reset cfg");
        u_kms_host_model.read_keys(rd);
        chk(32'(rd), 32'(31'h7FFFFFFF), "read in reset");
        pressed = 30'h1;
        wait_cyc(800);
        chk(32'(keyPending), 32'h0, "scan in reset");
        pressed = '0;
        send(2'h0);
        send(2'h2);
        chk(32'(displayOn), 32'h0, "early release");
        send(2'h1);
        chk(32'(displayOn), 32'h1, "release");
        chk(32'(scanDrive), 32'(DRIVE_ALL), "idle lines");
        for (int t = 0; t < 3; t++) begin
            seed = xs(seed);
            k = int'(seed % 30);
            pressed = 30'h1 << k;
            wait_pend(n);
            chk_win(n, 570, 600, "confirm time");
            chk(32'(soOe), 32'h1, "request low");
            pressed |= 30'h1 << ((k + 7) % 30);
            wait_cyc(700);
            chk(32'(keyPending), 32'h1, "map held");
            chk(32'(scanDrive), 32'(DRIVE_ALL), "multi key lines");
            fork
                u_kms_host_model.write_frame(frame(2'h1, c, seed));
                begin
                    #1000;
                    chk(32'(soOe), 32'h0, "float during write");
                end
            join
            wait_cyc(5);
            chk(32'(soOe), 32'h1, "request back");
            read_chk({1'b0, 30'h1 << k});
        end
        pressed = 30'h1;
        wait_cyc(400);
        pressed = 30'h1 << 25;
        wait_pend(n);
        chk_win(n + 400, 1190, 1235, "rescan time");
        read_chk({1'b0, 30'h1 << 25});
        c.saveHi = 1'b1;
        fork
            send(2'h0);
            begin
                #1500;
                chk(32'(cfgOut), 32'h0, "cfg early");
            end
        join
        chk(32'(cfgOut), 32'(c), "cfg");
        chk(32'(scanDrive), 32'(SAVE2_LINES), "save idle lines");
        pressed = 30'h1;
        wait_cyc(700);
        chk(32'(keyPending), 32'h0, "invalid line key");
        k = 25 + int'(seed % 5);
        pressed = 30'h1 << k;
        clkEn = 1'b0;
        wait_cyc(100);
        clkEn = 1'b1;
        chk(32'(keyPending), 32'h0, "frozen scan");
        wait_pend(n);
        chk_win(n + 100, 670, 700, "save confirm");
        read_chk({1'b1, 30'h1 << k});
        chk(32'(cfgOut), 32'(c), "save kept");
        give_verdict();
    end
endmodule : tb_kms_key_scan
